/* File: hw/hvc_busy_timer.sv */
// interface latency timer for the command port
// assumes start is a one-cycle pulse, ignored while running
`timescale 1ns/1ps
`default_nettype none
module hvc_busy_timer #(
  parameter int CYCLES = 400
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  logic [15:0] count;
  wire         last = (count == 16'h0001);
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      count  <= 16'h0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && last;
      if (start_i && !busy_o) begin
        count  <= 16'(CYCLES);
        busy_o <= 1'b1;
      end else if (busy_o) begin
        count  <= count - 16'h0001;
        busy_o <= !last;
      end
    end
  end
endmodule : hvc_busy_timer
`default_nettype wire

/* File: hw/hvc_config_bank.sv */
// indirect high-voltage configuration bank behind command and data ports
// assumes processor writes are single-cycle strobes on the bus clock
// Operation
// - bit 7 set blocks automatic thermal shutdown of wake/serial driver
// - bit 6 enables precision oscillator; clear powers it down
// - bit 5 clear keeps bus pull-up; set selects alternate sensor bus
// - bit 4 set drives wake-up pin high, clear pulls it low
// - bit 3 enables supply monitor; interrupt when unmasked and supply low
// - bit 2 enables low-voltage flag latch, seen in monitor status bit 3
// - bits 1-0 select transceiver mode off, reserved, on, fast
// - second register is 8-bit, resets 0x00, command-port access only
// - data port holds write data first and returns read-back values
// - commands 0x00/0x01 read, 0x08/0x09 write the two registers
`timescale 1ns/1ps
`default_nettype none
module hvc_config_bank
  import hvc_pkg::*;
#(
  parameter int LATENCY = HVC_LATENCY_CYC
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // command port
  input  wire logic        cmd_wr_i,
  input  wire logic [7:0]  cmd_wdata_i,
  output logic      [7:0]  cmd_rdata_o,
  // data port
  input  wire logic        dat_wr_i,
  input  wire logic [7:0]  dat_wdata_i,
  output logic      [11:0] dat_rdata_o,
  // analogue side status
  input  wire logic        supply_low_i,
  input  wire logic        core_low_i,
  input  wire logic [31:0] interrupt_enable_mask_i,
  input  wire logic [7:0]  hv_status_register_i,
  // controls to high-voltage circuits
  output logic             tsd_override_o,
  output logic             osc_enable_o,
  output logic             alt_sensor_bus_o,
  output logic             bus_pullup_en_o,
  output logic             wakeup_pin_high_o,
  output logic             supply_monitor_en_o,
  output logic             low_volt_flag_en_o,
  output logic             lin_driver_en_o,
  output logic             lin_fast_o,
  output logic             supply_drop_interrupt_o,
  output logic [7:0]       hv_config_one_o
);
  // ****************************************
  // command decode
  // ****************************************
  typedef enum logic [1:0] {HVC_IDLE, HVC_WAIT} hvc_state_t;
  hvc_state_t  state;
  logic [7:0]  hv_config_zero;
  logic [7:0]  hv_config_one;
  logic [7:0]  pend_cmd;
  logic [7:0]  dat_low;
  logic [3:0]  dat_tag;
  logic        rd_ok;
  logic        wr_ok;
  logic        low_flag;
  logic        busy;
  logic        done;
  function automatic logic is_known(input logic [7:0] c);
    is_known = (c == HVC_CMD_RD_CFG0) || (c == HVC_CMD_RD_CFG1) || (c == HVC_CMD_RD_STA)
            || (c == HVC_CMD_RD_MON) || (c == HVC_CMD_WR_CFG0) || (c == HVC_CMD_WR_CFG1);
  endfunction : is_known
  // new commands while busy are dropped; software is expected to poll
  wire         accept   = cmd_wr_i && (state == HVC_IDLE);
  wire         is_write = (pend_cmd == HVC_CMD_WR_CFG0) || (pend_cmd == HVC_CMD_WR_CFG1);
  wire  [7:0]  monitor  = {4'h0, low_flag, 3'h0};
  wire  [7:0]  rd_value = (pend_cmd == HVC_CMD_RD_CFG0) ? hv_config_zero :
                          (pend_cmd == HVC_CMD_RD_CFG1) ? hv_config_one  :
                          (pend_cmd == HVC_CMD_RD_STA)  ? hv_status_register_i :
                          (pend_cmd == HVC_CMD_RD_MON)  ? monitor : dat_low;
  wire  [7:0]  next_cfg0 = (done && pend_cmd == HVC_CMD_WR_CFG0) ? dat_low : hv_config_zero;
  wire  [7:0]  next_cfg1 = (done && pend_cmd == HVC_CMD_WR_CFG1) ? dat_low : hv_config_one;

  // ****************************************
  // interface latency timer
  // ****************************************
  hvc_busy_timer #(
    .CYCLES (LATENCY)
  ) u_timer (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .start_i (accept),
    .busy_o  (busy),
    .done_o  (done)
  );

  // ****************************************
  // state and storage
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state          <= HVC_IDLE;
      pend_cmd       <= 8'h00;
      dat_low        <= 8'h00;
      dat_tag        <= 4'h0;
      rd_ok          <= 1'b0;
      wr_ok          <= 1'b0;
      hv_config_zero <= HVC_CFG0_RST;
      hv_config_one  <= HVC_CFG1_RST;
    end else begin
      hv_config_zero <= next_cfg0;
      hv_config_one  <= next_cfg1;
      case (state)
        HVC_IDLE: begin
          if (dat_wr_i) begin
            dat_low <= dat_wdata_i;
          end
          if (accept) begin
            pend_cmd <= cmd_wdata_i;
            rd_ok    <= 1'b0;
            wr_ok    <= 1'b0;
            state    <= HVC_WAIT;
          end
        end
        HVC_WAIT: begin
          if (done) begin
            dat_low <= is_write ? dat_low : rd_value;
            dat_tag <= pend_cmd[3:0];
            rd_ok   <= !is_write && is_known(pend_cmd);
            wr_ok   <= is_write;
            state   <= HVC_IDLE;
          end
        end
        default: state <= HVC_IDLE;
      endcase
    end
  end

  // ****************************************
  // low-voltage flag, latched while enabled
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      low_flag <= 1'b0;
    end else if (hv_config_zero[HVC_BIT_LVF_EN] && core_low_i) begin
      low_flag <= 1'b1;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cmd_rdata_o             <= 8'h00;
      dat_rdata_o             <= 12'h000;
      tsd_override_o          <= 1'b0;
      osc_enable_o            <= 1'b0;
      alt_sensor_bus_o        <= 1'b0;
      bus_pullup_en_o         <= 1'b1;
      wakeup_pin_high_o       <= 1'b0;
      supply_monitor_en_o     <= 1'b0;
      low_volt_flag_en_o      <= 1'b0;
      lin_driver_en_o         <= 1'b0;
      lin_fast_o              <= 1'b0;
      supply_drop_interrupt_o <= 1'b0;
      hv_config_one_o         <= HVC_CFG1_RST;
    end else begin
      cmd_rdata_o             <= {5'h00, wr_ok, rd_ok, busy || (state == HVC_WAIT)};
      dat_rdata_o             <= {dat_tag, dat_low};
      tsd_override_o          <= next_cfg0[HVC_BIT_TSD_DIS];
      osc_enable_o            <= next_cfg0[HVC_BIT_OSC_EN];
      alt_sensor_bus_o        <= next_cfg0[HVC_BIT_ALT_BUS];
      bus_pullup_en_o         <= !next_cfg0[HVC_BIT_ALT_BUS];
      wakeup_pin_high_o       <= next_cfg0[HVC_BIT_WAKEUP];
      supply_monitor_en_o     <= next_cfg0[HVC_BIT_SVM_EN];
      low_volt_flag_en_o      <= next_cfg0[HVC_BIT_LVF_EN];
      lin_driver_en_o         <= next_cfg0[HVC_BIT_MODE_HI];
      lin_fast_o              <= next_cfg0[HVC_BIT_MODE_HI:HVC_BIT_MODE_LO] == HVC_MODE_FAST;
      supply_drop_interrupt_o <= hv_config_zero[HVC_BIT_SVM_EN] && interrupt_enable_mask_i[HVC_BIT_SUPPLY_IRQ]
                                 && supply_low_i;
      hv_config_one_o         <= next_cfg1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_tsd;
    @(posedge clock_i) disable iff (!rst_n_i)
      done && pend_cmd == HVC_CMD_WR_CFG0 |=> tsd_override_o == $past(dat_low[HVC_BIT_TSD_DIS]);
  endproperty
  a_tsd: assert property (p_tsd) else $error("thermal override mismatch");
  property p_osc;
    @(posedge clock_i) disable iff (!rst_n_i)
      done && pend_cmd == HVC_CMD_WR_CFG0 |=> osc_enable_o == $past(dat_low[HVC_BIT_OSC_EN]);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable mismatch");
  property p_pull;
    @(posedge clock_i) disable iff (!rst_n_i) ##1 bus_pullup_en_o != alt_sensor_bus_o;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up and alternate bus both set");
  property p_wake;
    @(posedge clock_i) disable iff (!rst_n_i)
      done && pend_cmd == HVC_CMD_WR_CFG0 |=> wakeup_pin_high_o == $past(dat_low[HVC_BIT_WAKEUP]);
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up pin mismatch");
  property p_irq;
    @(posedge clock_i) disable iff (!rst_n_i)
      supply_drop_interrupt_o |-> $past(supply_low_i) && $past(hv_config_zero[HVC_BIT_SVM_EN]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without low supply");
  property p_flag;
    @(posedge clock_i) disable iff (!rst_n_i) low_flag |=> low_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("low-voltage flag lost");
  property p_fast;
    @(posedge clock_i) disable iff (!rst_n_i) lin_fast_o |-> lin_driver_en_o;
  endproperty
  a_fast: assert property (p_fast) else $error("fast mode without driver");
  property p_cfg1;
    @(posedge clock_i) disable iff (!rst_n_i)
      $changed(hv_config_one) |-> $past(done) && $past(pend_cmd) == HVC_CMD_WR_CFG1;
  endproperty
  a_cfg1: assert property (p_cfg1) else $error("config one changed without write");
  property p_rdback;
    @(posedge clock_i) disable iff (!rst_n_i)
      done && pend_cmd == HVC_CMD_RD_CFG1 |=> ##1 dat_rdata_o[7:0] == $past(hv_config_one, 2);
  endproperty
  a_rdback: assert property (p_rdback) else $error("read-back mismatch");
  property p_cfg0;
    @(posedge clock_i) disable iff (!rst_n_i)
      $changed(hv_config_zero) |-> $past(done) && $past(pend_cmd) == HVC_CMD_WR_CFG0;
  endproperty
  a_cfg0: assert property (p_cfg0) else $error("config zero changed without write");
endmodule : hvc_config_bank
`default_nettype wire

/* File: hw/hvc_pkg.sv */
// package for the indirect high-voltage configuration bank
// assumes a single 40 MHz processor bus clock domain
package hvc_pkg;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] HVC_CMD_RD_CFG0 = 8'h00;
  localparam logic [7:0] HVC_CMD_RD_CFG1 = 8'h01;
  localparam logic [7:0] HVC_CMD_RD_STA  = 8'h02;
  localparam logic [7:0] HVC_CMD_RD_MON  = 8'h03;
  localparam logic [7:0] HVC_CMD_WR_CFG0 = 8'h08;
  localparam logic [7:0] HVC_CMD_WR_CFG1 = 8'h09;
  // ****************************************
  // field positions of configuration zero, the supply interrupt mask and monitor status
  // ****************************************
  localparam int HVC_BIT_TSD_DIS = 7;
  localparam int HVC_BIT_OSC_EN  = 6;
  localparam int HVC_BIT_ALT_BUS = 5;
  localparam int HVC_BIT_WAKEUP  = 4;
  localparam int HVC_BIT_SVM_EN  = 3;
  localparam int HVC_BIT_LVF_EN  = 2;
  localparam int HVC_BIT_MODE_HI = 1;
  localparam int HVC_BIT_MODE_LO = 0;
  localparam int HVC_BIT_SUPPLY_IRQ = 16;
  localparam int HVC_BIT_LVF_MON = 3;
  // ****************************************
  // status bits of the command port
  // ****************************************
  localparam int HVC_BIT_BUSY = 0;
  localparam int HVC_BIT_RDOK = 1;
  localparam int HVC_BIT_WROK = 2;
  // ****************************************
  // reset values, timing and transceiver mode codes
  // ****************************************
  localparam logic [7:0] HVC_CFG0_RST = 8'h00;
  localparam logic [7:0] HVC_CFG1_RST = 8'h00;
  localparam int HVC_CLK_HZ           = 40000000;
  localparam int HVC_LATENCY_NS       = 10000;
  localparam int HVC_LATENCY_CYC      = (HVC_LATENCY_NS * (HVC_CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [1:0] HVC_MODE_OFF  = 2'h0;
  localparam logic [1:0] HVC_MODE_RSVD = 2'h1;
  localparam logic [1:0] HVC_MODE_ON   = 2'h2;
  localparam logic [1:0] HVC_MODE_FAST = 2'h3;
endpackage : hvc_pkg

/* File: sim/hvc_sw_model.sv */
// processor-side model driving the command and data ports of the bank
// assumes the bank samples strobes on the rising edge of clock_i
`timescale 1ns/1ps
`default_nettype none
module hvc_sw_model (
  // clock and status
  input  wire logic       clock_i,
  input  wire logic [7:0] cmd_rdata_i,
  // port writes
  output logic            cmd_wr_o,
  output logic [7:0]      cmd_wdata_o,
  output logic            dat_wr_o,
  output logic [7:0]      dat_wdata_o
);
  int hangs = 0;
  initial begin
    {cmd_wr_o, dat_wr_o} = 2'b00;
    {cmd_wdata_o, dat_wdata_o} = 16'h0000;
  end
  // released bytes are inverted so stale data never looks valid
  task automatic put_data(input logic [7:0] d);
    @(posedge clock_i) #1;
    {dat_wr_o, dat_wdata_o} = {1'b1, d};
    @(posedge clock_i) #1;
    {dat_wr_o, dat_wdata_o} = {1'b0, ~d};
  endtask : put_data
  // obey low skips the busy poll; full low returns once busy shows
  task automatic send_cmd(input logic [7:0] c, input bit obey, input bit full, input int gap);
    int n;
    repeat (gap) @(posedge clock_i) #1;
    // status is polled just after the edge so a freshly launched value is settled
    for (n = 0; obey && cmd_rdata_i[0] !== 1'b0 && n < 200; n++) begin
      @(posedge clock_i) #1;
    end
    if (n == 200) hangs++;
    @(posedge clock_i) #1;
    {cmd_wr_o, cmd_wdata_o} = {1'b1, c};
    @(posedge clock_i) #1;
    {cmd_wr_o, cmd_wdata_o} = {1'b0, ~c};
    for (n = 0; cmd_rdata_i[0] !== 1'b1 && n < 10; n++) begin
      @(posedge clock_i) #1;
    end
    if (n == 10) hangs++;
    for (n = 0; full && cmd_rdata_i[0] !== 1'b0 && n < 200; n++) begin
      @(posedge clock_i) #1;
    end
    if (n == 200) hangs++;
    @(posedge clock_i) #1;
  endtask : send_cmd
endmodule : hvc_sw_model
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the indirect configuration bank
// assumes a shortened command latency of 8 cycles, long enough to land refused writes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hvc_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        supply_low = 1'b0;
  logic        core_low = 1'b0;
  logic [31:0] mask = 32'h0000_0000;
  wire logic   cmd_wr, dat_wr, tsd, osc, alt, pul, wak, svm, lvf, drv, fst, irq;
  wire logic [7:0]  cmd_wd, dat_wd, cmd_rd, cfg1;
  wire logic [11:0] dat_rd;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  initial forever #12.5 clock_i = ~clock_i;
  hvc_config_bank #(.LATENCY(8)) u_hvc_config_bank (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .cmd_wr_i(cmd_wr), .cmd_wdata_i(cmd_wd), .cmd_rdata_o(cmd_rd), .dat_wr_i(dat_wr),
    .dat_wdata_i(dat_wd), .dat_rdata_o(dat_rd), .supply_low_i(supply_low), .core_low_i(core_low),
    .interrupt_enable_mask_i(mask), .hv_status_register_i(8'hA5), .tsd_override_o(tsd),
    .osc_enable_o(osc), .alt_sensor_bus_o(alt), .bus_pullup_en_o(pul), .wakeup_pin_high_o(wak),
    .supply_monitor_en_o(svm), .low_volt_flag_en_o(lvf), .lin_driver_en_o(drv), .lin_fast_o(fst),
    .supply_drop_interrupt_o(irq), .hv_config_one_o(cfg1));
  hvc_sw_model u_hvc_sw_model (.clock_i(clock_i), .cmd_rdata_i(cmd_rd), .cmd_wr_o(cmd_wr),
    .cmd_wdata_o(cmd_wd), .dat_wr_o(dat_wr), .dat_wdata_o(dat_wd));
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic ctl_chk(input logic [7:0] p);
    check({3'h0, tsd, osc, alt, pul, wak, svm, lvf, drv, fst}, {3'h0, p[7:5], ~p[5], p[4:1], &p[1:0]});
  endtask : ctl_chk
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input int gap);
    u_hvc_sw_model.put_data(d);
    u_hvc_sw_model.send_cmd(c, 1'b1, 1'b1, gap);
    check({4'h0, cmd_rd}, 12'h004);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [7:0] d);
    u_hvc_sw_model.send_cmd(c, 1'b1, 1'b1, 0);
    check(dat_rd, {c[3:0], d});
    check({4'h0, cmd_rd}, 12'h002);
  endtask : rd
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    repeat (10) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    ctl_chk(8'h00);
    check({3'h0, irq, cfg1}, 12'h000);
    rd(HVC_CMD_RD_CFG1, 8'h00);
  endtask : t_reset
  task automatic t_cfg0;
    logic [7:0] pats[8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0B, 8'h05, 8'h02, 8'h00};
    foreach (pats[i]) begin
      wr(HVC_CMD_WR_CFG0, pats[i], i);
      ctl_chk(pats[i]);
      rd(HVC_CMD_RD_CFG0, pats[i]);
    end
  endtask : t_cfg0
  task automatic t_cfg1;
    wr(HVC_CMD_WR_CFG1, 8'h5A, 7);
    check({4'h0, cfg1}, 12'h05A);
    rd(HVC_CMD_RD_CFG1, 8'h5A);
    rd(HVC_CMD_RD_STA, 8'hA5);
    u_hvc_sw_model.send_cmd(8'h05, 1'b1, 1'b1, 0);
    check({4'h0, cmd_rd}, 12'h000);
    check(dat_rd, 12'h5A5);
  endtask : t_cfg1
  // a command and a data write landing while busy must change nothing
  task automatic t_refused;
    u_hvc_sw_model.put_data(8'h3C);
    u_hvc_sw_model.send_cmd(HVC_CMD_WR_CFG1, 1'b1, 1'b0, 0);
    u_hvc_sw_model.put_data(8'hFF);
    u_hvc_sw_model.send_cmd(HVC_CMD_WR_CFG0, 1'b0, 1'b0, 0);
    rd(HVC_CMD_RD_CFG1, 8'h3C);
    ctl_chk(8'h00);
  endtask : t_refused
  task automatic t_monitor;
    wr(HVC_CMD_WR_CFG0, 8'h0C, 0);
    {supply_low, mask} = {1'b1, 32'h0001_0000};
    repeat (3) @(posedge clock_i) #1;
    check({11'h0, irq}, 12'h001);
    mask = 32'h0000_0000;
    repeat (3) @(posedge clock_i) #1;
    check({11'h0, irq}, 12'h000);
    core_low = 1'b1;
    repeat (2) @(posedge clock_i) #1;
    core_low = 1'b0;
    rd(HVC_CMD_RD_MON, 8'h08);
    rst_n_i = 1'b0;
    t_reset();
    rd(HVC_CMD_RD_MON, 8'h00);
  endtask : t_monitor
  task automatic finish_test;
    mismatches += u_hvc_sw_model.hangs;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // limit covers 28 commands of some fifteen cycles each, with margin
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    t_reset();
    t_cfg0();
    t_cfg1();
    t_refused();
    t_monitor();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
